// >>> hdl/iad_decoder.sv
`timescale 1ns/1ps
module iad_decoder
  import iad_pkg::*;
(
  // clock and reset
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_i,
  // pointers held by the core
  input  wire logic [iad_pkg::BYTE_W-1:0]   ptr0_high_byte_i,
  input  wire logic [iad_pkg::BYTE_W-1:0]   ptr0_low_byte_i,
  input  wire logic [iad_pkg::BYTE_W-1:0]   ptr1_high_byte_i,
  input  wire logic [iad_pkg::BYTE_W-1:0]   ptr1_low_byte_i,
  // indirect port request from execution
  input  wire logic                         req_valid_i,
  input  wire logic                         req_write_i,
  input  wire logic                         req_ptr_sel_i,
  input  wire logic [iad_pkg::BYTE_W-1:0]   req_wdata_i,
  output logic                              req_ready_o,
  // answer to execution
  output logic                              rsp_done_o,
  output logic                              rsp_flash_o,
  output logic      [iad_pkg::BYTE_W-1:0]   rsp_rdata_o,
  // data memory side
  output logic      [iad_pkg::ABS_W-1:0]    dmem_addr_o,
  output logic                              dmem_re_o,
  output logic                              dmem_we_o,
  output logic      [iad_pkg::BYTE_W-1:0]   dmem_wdata_o,
  input  wire logic [iad_pkg::BYTE_W-1:0]   dmem_rdata_i,
  // program flash side, read only
  output logic      [iad_pkg::FLASH_AW-1:0] pmem_addr_o,
  output logic                              pmem_re_o,
  input  wire logic [iad_pkg::FLASH_DW-1:0] pmem_rdata_i
);
  import iad_pkg::*;

  iad_state_t          state_reg;
  iad_state_t          state_next;
  iad_kind_t           kind_reg;
  iad_kind_t           kind_next;
  logic                write_reg;
  logic [BYTE_W-1:0]   wdata_reg;
  logic [ABS_W-1:0]    abs_reg;
  logic [FLASH_AW-1:0] faddr_reg;
  logic [BYTE_W-1:0]   rdata_reg;
  logic [BYTE_W-1:0]   rdata_next;

  logic [PTR_W-1:0]    ptr_w;
  logic [ABS_W-1:0]    trad_addr_w;
  logic [FLASH_AW-1:0] flash_addr_w;
  logic [ABS_W-1:0]    lin_off_w;
  logic [ABS_W-1:0]    lin_abs_w;
  logic                is_flash_w;
  logic                is_trad_w;
  logic                is_lin_w;
  logic                self_ref_w;
  logic                take_w;
  logic                access_w;

  // pointer selection and concatenation
  assign ptr_w        = req_ptr_sel_i ? {ptr1_high_byte_i, ptr1_low_byte_i}
                                      : {ptr0_high_byte_i, ptr0_low_byte_i};
  assign trad_addr_w  = ptr_w[ABS_W-1:0];
  assign flash_addr_w = ptr_w[FLASH_AW-1:0];
  assign is_flash_w   = ptr_w[FLASH_BIT];
  assign is_trad_w    = ptr_w <= TRAD_LAST;
  assign is_lin_w     = (ptr_w >= LIN_BASE) && (ptr_w <= LIN_LAST);
  assign lin_off_w    = 12'(ptr_w - LIN_BASE);
  // the two ports sit at the same two offsets in every bank
  assign self_ref_w   = is_trad_w && ((ptr_w[OFF_W-1:0] == PORT0_OFF) ||
                                      (ptr_w[OFF_W-1:0] == PORT1_OFF));

  iad_lin_map u_lin_map (
    .lin_off_i  (lin_off_w),
    .abs_addr_o (lin_abs_w)
  );

  // everything else, the gap above the traditional region included, reads as zero
  assign kind_next = is_flash_w                             ? KD_FLASH :
                     ((is_trad_w && !self_ref_w) || is_lin_w) ? KD_DATA  : KD_NONE;

  assign take_w   = req_valid_i && (state_reg == ST_IDLE);
  assign access_w = state_reg == ST_ACCESS;

  assign req_ready_o  = state_reg == ST_IDLE;
  assign rsp_done_o   = state_reg == ST_DONE;
  assign rsp_flash_o  = rsp_done_o && (kind_reg == KD_FLASH);
  assign rsp_rdata_o  = rdata_reg;
  assign dmem_addr_o  = abs_reg;
  assign dmem_wdata_o = wdata_reg;
  assign dmem_re_o    = access_w && (kind_reg == KD_DATA) && !write_reg;
  // flash and zero regions never raise a write strobe
  assign dmem_we_o    = access_w && (kind_reg == KD_DATA) && write_reg;
  assign pmem_addr_o  = faddr_reg;
  assign pmem_re_o    = access_w && (kind_reg == KD_FLASH) && !write_reg;

  assign rdata_next = (kind_reg == KD_DATA)  ? dmem_rdata_i :
                      (kind_reg == KD_FLASH) ? pmem_rdata_i[BYTE_W-1:0] : ZERO_BYTE;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:   state_next = take_w ? ST_ACCESS : ST_IDLE;
      ST_ACCESS: state_next = (kind_reg == KD_FLASH) ? ST_EXTRA : ST_DONE;
      ST_EXTRA:  state_next = ST_DONE;
      ST_DONE:   state_next = ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      kind_reg  <= KD_NONE;
      write_reg <= 1'b0;
      wdata_reg <= ZERO_BYTE;
      abs_reg   <= ABS_RESET;
      faddr_reg <= FLASH_RESET;
    end else if (take_w) begin
      kind_reg  <= kind_next;
      write_reg <= req_write_i;
      wdata_reg <= req_wdata_i;
      abs_reg   <= is_lin_w ? lin_abs_w : trad_addr_w;
      faddr_reg <= flash_addr_w;
    end
  end

  // read data held until the next read access loads it; writes leave it unchanged
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_reg <= ZERO_BYTE;
    end else if (access_w && !write_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  // checks
  logic [ABS_W-1:0] lin_rem_w;
  assign lin_rem_w = lin_off_w % GPR_BYTES;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_port_redirect;
    take_w && !req_write_i && (kind_next == KD_DATA) |=> dmem_re_o ##1 rsp_done_o;
  endproperty
  a_port_redirect: assert property (p_port_redirect) else $error("data read not redirected");

  property p_self_ref_zero;
    take_w && !req_write_i && self_ref_w |-> ##2 rsp_done_o && (rsp_rdata_o == ZERO_BYTE);
  endproperty
  a_self_ref_zero: assert property (p_self_ref_zero) else $error("self reference read not zero");

  property p_self_ref_nowrite;
    take_w && self_ref_w |=> !dmem_we_o [*2];
  endproperty
  a_self_ref_nowrite: assert property (p_self_ref_nowrite) else $error("self reference write issued");

  property p_trad_addr;
    take_w && is_trad_w && !self_ref_w |=> dmem_addr_o == $past(trad_addr_w);
  endproperty
  a_trad_addr: assert property (p_trad_addr) else $error("traditional address wrong");

  property p_lin_window;
    take_w && is_lin_w |=> (dmem_addr_o[OFF_W-1:0] >= GPR_START) && (dmem_addr_o[OFF_W-1:0] < COMMON_START);
  endproperty
  a_lin_window: assert property (p_lin_window) else $error("linear address outside ram block");

  property p_lin_next_bank;
    take_w && is_lin_w && (lin_rem_w == ABS_RESET) && (lin_off_w != ABS_RESET)
      |=> (dmem_addr_o[OFF_W-1:0] == GPR_START) && (dmem_addr_o[ABS_W-1:OFF_W] != 5'h00);
  endproperty
  a_lin_next_bank: assert property (p_lin_next_bank) else $error("linear bank step wrong");

  property p_unimpl_zero;
    take_w && !req_write_i && (kind_next == KD_NONE) |=> !dmem_re_o && !pmem_re_o ##1 rsp_rdata_o == ZERO_BYTE;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented read not zero");

  property p_flash_addr;
    take_w && is_flash_w && !req_write_i |=> pmem_re_o && (pmem_addr_o == $past(flash_addr_w));
  endproperty
  a_flash_addr: assert property (p_flash_addr) else $error("flash address wrong");

  property p_flash_low;
    pmem_re_o |=> rsp_rdata_o == $past(pmem_rdata_i[BYTE_W-1:0]);
  endproperty
  a_flash_low: assert property (p_flash_low) else $error("flash low byte wrong");

  property p_flash_nowrite;
    take_w && is_flash_w && req_write_i |=> (!dmem_we_o && !pmem_re_o) [*3];
  endproperty
  a_flash_nowrite: assert property (p_flash_nowrite) else $error("flash write had effect");

  property p_flash_extra;
    take_w && is_flash_w |=> !rsp_done_o ##1 !rsp_done_o ##1 rsp_done_o && rsp_flash_o;
  endproperty
  a_flash_extra: assert property (p_flash_extra) else $error("flash extra cycle missing");

  // data and zero-region accesses must not pay the flash penalty
  property p_data_timing;
    take_w && (kind_next != KD_FLASH) |=> !rsp_done_o ##1 rsp_done_o && !rsp_flash_o;
  endproperty
  a_data_timing: assert property (p_data_timing) else $error("data access timing wrong");

  property p_write_data;
    take_w && req_write_i && (kind_next == KD_DATA) |=> dmem_we_o && (dmem_wdata_o == $past(req_wdata_i));
  endproperty
  a_write_data: assert property (p_write_data) else $error("redirected write data wrong");

  // done is a single pulse, after which the port is free again
  property p_done_pulse;
    rsp_done_o |=> !rsp_done_o && req_ready_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");

  c_trad_read: cover property (take_w && is_trad_w && !self_ref_w && !req_write_i ##2 rsp_done_o);
  c_lin_write: cover property (take_w && is_lin_w && req_write_i ##1 dmem_we_o);
  c_flash_read: cover property (take_w && is_flash_w ##3 rsp_flash_o);
  c_self_ref: cover property (take_w && self_ref_w);
endmodule

// >>> pkg/iad_pkg.sv
// Behaviour
// - an indirect port access really accesses the location the selected pointer holds
// - pointer aimed at either indirect port: read returns zero, write dropped
// - pointer is high byte concatenated with low byte, 16 bits, 65536 locations
// - pointer 0x000 to 0xFFF maps straight onto absolute data addresses
// - pointer 0x2000 to 0x29AF is a linear view of the 80-byte RAM blocks
// - linear address past a bank's last RAM byte lands on next bank's first
// - reads of unimplemented locations through the pointer return 0x00
// - linear view leaves out the 16 common bytes of every bank
// - pointer high byte MSB set: lower 15 bits address program flash
// - flash read through the port returns only the low 8 bits of the word
// - writes aimed at program flash change nothing
// - any flash access through the port takes one extra instruction cycle
package iad_pkg;
  localparam int          PTR_W        = 16;
  localparam int          BYTE_W       = 8;
  localparam int          ABS_W        = 12;
  localparam int          OFF_W        = 7;
  localparam int          BANK_W       = 5;
  localparam int          FLASH_AW     = 15;
  localparam int          FLASH_DW     = 14;
  localparam int          FLASH_BIT    = 15;
  localparam logic [15:0] TRAD_LAST    = 16'h0FFF;
  localparam logic [15:0] LIN_BASE     = 16'h2000;
  localparam logic [15:0] LIN_LAST     = 16'h29AF;
  localparam logic [11:0] GPR_BYTES    = 12'h050;
  localparam logic [6:0]  GPR_START    = 7'h20;
  localparam logic [6:0]  COMMON_START = 7'h70;
  localparam logic [6:0]  PORT0_OFF    = 7'h00;
  localparam logic [6:0]  PORT1_OFF    = 7'h01;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  localparam logic [11:0] ABS_RESET    = 12'h000;
  localparam logic [14:0] FLASH_RESET  = 15'h0000;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ACCESS = 4'h2,
    ST_EXTRA  = 4'h4,
    ST_DONE   = 4'h8
  } iad_state_t;

  typedef enum logic [2:0] {
    KD_DATA  = 3'h1,
    KD_FLASH = 3'h2,
    KD_NONE  = 3'h4
  } iad_kind_t;
endpackage

// >>> hdl/iad_lin_map.sv
`timescale 1ns/1ps
module iad_lin_map
  import iad_pkg::*;
(
  // linear offset from the region base
  input  wire logic [iad_pkg::ABS_W-1:0] lin_off_i,
  // absolute banked address
  output logic      [iad_pkg::ABS_W-1:0] abs_addr_o
);
  import iad_pkg::*;

  logic [ABS_W-1:0] quot_w;
  logic [ABS_W-1:0] rem_w;
  logic [OFF_W-1:0] off_w;

  // constant divisor keeps this a small combinational network
  assign quot_w     = lin_off_i / GPR_BYTES;
  assign rem_w      = lin_off_i % GPR_BYTES;
  assign off_w      = 7'(GPR_START + rem_w[OFF_W-1:0]);
  assign abs_addr_o = {quot_w[BANK_W-1:0], off_w};
endmodule

// >>> tb/iad_mem_model.sv
`timescale 1ns/1ps
module iad_mem_model (
  // clock
  input  wire logic        core_clk_i,
  // data memory
  input  wire logic [11:0] dmem_addr_i,
  input  wire logic        dmem_re_i,
  input  wire logic        dmem_we_i,
  input  wire logic [7:0]  dmem_wdata_i,
  output logic      [7:0]  dmem_rdata_o,
  // program flash
  input  wire logic [14:0] pmem_addr_i,
  input  wire logic        pmem_re_i,
  output logic      [13:0] pmem_rdata_o
);
  logic [7:0] mem [4096];
  logic       tog_reg = 1'b0;
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ 8'h3C;
    end
  end
  // unread lines toggle so stale data is never mistaken for an answer
  // plain always: the array is also preset by the initial block
  always @(posedge core_clk_i) begin
    tog_reg <= ~tog_reg;
    if (dmem_we_i) begin
      mem[dmem_addr_i] <= dmem_wdata_i;
    end
  end
  assign dmem_rdata_o = dmem_re_i ? mem[dmem_addr_i] : {8{tog_reg}} ^ 8'hA5;
  // high flash bits set so a full-word leak shows
  assign pmem_rdata_o = pmem_re_i ? {6'h2A, pmem_addr_i[7:0] ^ 8'h5A} : {14{tog_reg}};
endmodule

// >>> tb/test_indirect_address_decoder.sv
`timescale 1ns/1ps
module test_indirect_address_decoder;
  import iad_pkg::*;
  logic        core_clk_i, rst_i, req_valid_i, req_write_i, req_ptr_sel_i;
  logic        req_ready_o, rsp_done_o, rsp_flash_o, dmem_re_o, dmem_we_o, pmem_re_o;
  logic [7:0]  p0h, p0l, p1h, p1l, req_wdata_i, rsp_rdata_o, dmem_wdata_o, dmem_rdata_i, rd;
  logic [11:0] dmem_addr_o, ea;
  logic [14:0] pmem_addr_o;
  logic [13:0] pmem_rdata_i;
  logic [15:0] tp [4];
  logic        fl, sre, swe, spre;
  int          ncyc;
  int          err_count = 0;
  int          tests_run = 0;

  iad_decoder dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ptr0_high_byte_i(p0h), .ptr0_low_byte_i(p0l),
    .ptr1_high_byte_i(p1h), .ptr1_low_byte_i(p1l), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_ptr_sel_i(req_ptr_sel_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
    .rsp_done_o(rsp_done_o), .rsp_flash_o(rsp_flash_o), .rsp_rdata_o(rsp_rdata_o),
    .dmem_addr_o(dmem_addr_o), .dmem_re_o(dmem_re_o), .dmem_we_o(dmem_we_o), .dmem_wdata_o(dmem_wdata_o),
    .dmem_rdata_i(dmem_rdata_i), .pmem_addr_o(pmem_addr_o), .pmem_re_o(pmem_re_o), .pmem_rdata_i(pmem_rdata_i));
  iad_mem_model part (.core_clk_i(core_clk_i), .dmem_addr_i(dmem_addr_o), .dmem_re_i(dmem_re_o),
    .dmem_we_i(dmem_we_o), .dmem_wdata_i(dmem_wdata_o), .dmem_rdata_o(dmem_rdata_i),
    .pmem_addr_i(pmem_addr_o), .pmem_re_i(pmem_re_o), .pmem_rdata_o(pmem_rdata_i));

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  // one access, request dropped after the take edge; strobes gathered till done
  task automatic acc(input logic sel, input logic wr, input logic [15:0] ptr, input logic [7:0] wd);
    int n;
    n = 0;
    sre = 1'b0;
    swe = 1'b0;
    spre = 1'b0;
    chk(16'(req_ready_o), 16'h1);
    req_ptr_sel_i = sel;
    req_write_i = wr;
    req_wdata_i = wd;
    if (sel) {p1h, p1l} = ptr; else {p0h, p0l} = ptr;
    req_valid_i = 1'b1;
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
    while (rsp_done_o !== 1'b1 && n < 8) begin
      sre |= dmem_re_o;
      swe |= dmem_we_o;
      spre |= pmem_re_o;
      n++;
      @(negedge core_clk_i);
    end
    ncyc = n + 1;
    chk(16'(rsp_done_o), 16'h1);
    rd = rsp_rdata_o;
    fl = rsp_flash_o;
    // the done cycle still refuses requests, so let it pass
    @(negedge core_clk_i);
  endtask

  task automatic t_trad;
    acc(1'b0, 1'b0, 16'h0123, 8'h00);
    chk(16'(dmem_addr_o), 16'h0123);
    chk(16'(rd), 16'(8'h23 ^ 8'h3C));
    chk(16'(ncyc), 16'h2);
    chk(16'(fl), 16'h0);
    acc(1'b1, 1'b1, 16'h0FFF, 8'h5C);
    chk(16'(swe), 16'h1);
    chk(16'(part.mem[12'hFFF]), 16'h005C);
    $display("test trad done");
  endtask

  task automatic t_self;
    acc(1'b0, 1'b0, 16'h0080, 8'h00);
    chk(16'(rd), 16'h0000);
    chk(16'(sre), 16'h0);
    acc(1'b1, 1'b1, 16'h0F81, 8'hEE);
    chk(16'(swe), 16'h0);
    chk(16'(part.mem[12'hF81]), 16'(8'h81 ^ 8'h3C));
    $display("test self done");
  endtask

  // 0x204F must land on 0x06F, not a common byte
  task automatic t_lin;
    tp = '{16'h2000, 16'h204F, 16'h2050, 16'h29AF};
    foreach (tp[i]) begin
      ea = {5'((tp[i] - 16'h2000) / 16'd80), 7'h20 + 7'((tp[i] - 16'h2000) % 16'd80)};
      acc(i[0], 1'b0, tp[i], 8'h00);
      chk(16'(dmem_addr_o), 16'(ea));
      chk(16'(rd), 16'(ea[7:0] ^ 8'h3C));
    end
    acc(1'b1, 1'b1, 16'h2050, 8'h96);
    chk(16'(part.mem[12'h0A0]), 16'h0096);
    $display("test lin done");
  endtask

  task automatic t_unimp;
    tp = '{16'h1000, 16'h1FFF, 16'h29B0, 16'h7FFF};
    foreach (tp[i]) begin
      acc(1'b0, 1'b0, tp[i], 8'h00);
      chk(16'(rd), 16'h0000);
      chk(16'({sre, spre}), 16'h0);
    end
    $display("test unimp done");
  endtask

  task automatic t_flash;
    tp = '{16'h8000, 16'h8123, 16'hFFFF, 16'hC0DE};
    foreach (tp[i]) begin
      acc(i[0], 1'b0, tp[i], 8'h00);
      chk(16'(pmem_addr_o), 16'(tp[i][14:0]));
      chk(16'(rd), 16'(tp[i][7:0] ^ 8'h5A));
      chk({ncyc[7:0], 7'h0, fl}, 16'h0301);
    end
    acc(1'b0, 1'b1, 16'hC000, 8'h77);
    chk(16'({swe, sre, ncyc[7:0]}), 16'h0003);
    chk(16'(spre), 16'h0);
    $display("test flash done");
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge core_clk_i);
    err_count++;
    test_done();
  end

  initial begin
    {rst_i, req_valid_i, req_write_i, req_ptr_sel_i} = 4'h8;
    {p0h, p0l, p1h, p1l, req_wdata_i} = '0;
    repeat (16) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_trad();
    t_self();
    t_lin();
    t_unimp();
    t_flash();
    test_done();
  end
endmodule
